// >>> hdl/ascr_pkg.sv
// ==========================================================================
// constants and types shared by the serial control block
package ascr_pkg;
  // register offsets on the plain register port (index = address)
  localparam logic [1:0] ADDR_STATUS = 2'h0;  // status flags, read only
  localparam logic [1:0] ADDR_DATA   = 2'h1;  // transmit hold / receive hold
  localparam logic [1:0] ADDR_CTRL1  = 2'h2;  // serial_control_one
  localparam logic [1:0] ADDR_CTRL2  = 2'h3;  // serial_control_two
  // serial_control_one fields
  localparam int C1_RX8    = 7;  // rx_ninth_bit, hardware written
  localparam int C1_TX8    = 6;  // ninth bit to transmit
  localparam int C1_LPD    = 5;  // low_power_disable
  localparam int C1_WLEN   = 4;  // word length, 1 = nine data bits
  localparam int C1_WAKE   = 3;  // 0 idle line, 1 address mark
  localparam int C1_PAREN  = 2;  // parity_enable
  localparam int C1_PARSEL = 1;  // parity_select, 1 = odd
  localparam int C1_PARIRQ = 0;  // parity_irq_enable
  // serial_control_two fields
  localparam int C2_TXEIRQ = 7;  // tx_empty_irq_enable
  localparam int C2_TXDIRQ = 6;  // tx_done_irq_enable
  localparam int C2_RXIRQ  = 5;  // rx_irq_enable
  localparam int C2_IDLIRQ = 4;  // idle_irq_enable
  localparam int C2_TXEN   = 3;  // transmitter_enable
  localparam int C2_RXEN   = 2;  // receiver_enable
  localparam int C2_MUTE   = 1;  // receiver_mute
  localparam int C2_BRK    = 0;  // send_break
  // reset values
  localparam logic [7:0] CTRL1_RESET  = 8'h00;
  localparam logic [7:0] CTRL2_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'hC0;  // both transmit flags set
  // frame lengths in bit times, start and stop included
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  // line timing: bit time in ns, cycles derived from the 10 ns clock
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BIT_TIME_NS     = 160;
  localparam int BIT_CYCLES_DEF  = BIT_TIME_NS / CLK_PERIOD_NS;
  // transmitter and receiver states, one-hot
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ascr_tx_state_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_SHIFT = 2'b10} ascr_rx_state_t;
  // what the transmitter is sending
  typedef enum logic [2:0] {K_DATA = 3'b001, K_PRE = 3'b010, K_BRK = 3'b100} ascr_kind_t;
  // whole state of the block
  typedef struct packed {
    logic [7:0]     ctrl1;        // serial_control_one
    logic [7:0]     ctrl2;        // serial_control_two
    logic [7:0]     status;       // serial_status_reg flags
    logic [7:0]     txHold;       // byte waiting to be sent
    logic [7:0]     rxHold;       // last byte received
    logic           statusRead;   // first half of a flag clear sequence
    ascr_tx_state_t txState;
    ascr_kind_t     txKind;
    logic [10:0]    txShift;
    logic [3:0]     txBitsLeft;
    logic [15:0]    txBaud;
    logic [15:0]    txDelay;      // wait after enabling the transmitter
    logic           pendPreamble;
    logic           pendBreak;
    logic           teDropped;    // enable went low during a frame
    logic           teEver;       // transmitter has been enabled once
    ascr_rx_state_t rxState;
    logic [10:0]    rxShift;
    logic [3:0]     rxBitsLeft;
    logic [15:0]    rxBaud;
    logic [15:0]    rxIdleCnt;
    logic           rxNine;       // frame settings latched at start bit
    logic           rxPar;
    logic           rxParOdd;
    logic           rxArmed;      // a word arrived since the last idle
    logic           txd;
    logic           txdOeN;
    logic           irq;
    logic [7:0]     rdata;
  } ascr_state_t;
endpackage

// >>> hdl/ascr_top.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ascr_top #(
  parameter int unsigned BIT_CYCLES = ascr_pkg::BIT_CYCLES_DEF  // clocks per bit time
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // serial line
  input  wire logic       rxd,
  output logic            txd,
  output logic            txdOeN,
  // interrupt
  output logic            serialIrq
);

  // ========================================================================
  // derived counts
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);   // baud reload
  localparam logic [15:0] BIT_HALF  = 16'(BIT_CYCLES / 2);   // start bit centre
  localparam logic [15:0] BIT_FULL  = 16'(BIT_CYCLES);       // enable delay
  localparam logic [15:0] IDLE_LIM8 = 16'(10 * BIT_CYCLES);  // one idle frame
  localparam logic [15:0] IDLE_LIM9 = 16'(11 * BIT_CYCLES);

  ascr_pkg::ascr_state_t r;  // registered state
  ascr_pkg::ascr_state_t n;  // next state

  // ========================================================================
  // combinational next state
  always_comb begin
    logic        dataWr;     // write to the data address
    logic        dataRd;     // read of the data address
    logic        txStartOk;  // transmitter may begin a frame
    logic [7:0]  txByte;     // byte with parity folded in
    logic        txNinth;    // ninth bit of an outgoing frame
    logic [10:0] rxWord;     // shift register after the last sample
    logic [7:0]  rxData;
    logic        rxNinthBit;
    logic        rxMsb;
    logic        rxParBad;
    logic        rxAccept;
    logic [15:0] idleLim;
    dataWr     = regWr && (regAddr == ascr_pkg::ADDR_DATA);
    dataRd     = regRd && (regAddr == ascr_pkg::ADDR_DATA);
    txStartOk  = 1'b0;
    txByte     = 8'h00;
    txNinth    = 1'b0;
    rxWord     = 11'h000;
    rxData     = 8'h00;
    rxNinthBit = 1'b0;
    rxMsb      = 1'b0;
    rxParBad   = 1'b0;
    rxAccept   = 1'b0;
    idleLim    = r.ctrl1[ascr_pkg::C1_WLEN] ? IDLE_LIM9 : IDLE_LIM8;
    n          = r;

    // ---- register writes
    if (regWr && regAddr == ascr_pkg::ADDR_CTRL1) begin
      // top bit belongs to the receiver, software cannot write it
      n.ctrl1 = {r.ctrl1[ascr_pkg::C1_RX8], regWrData[6:0]};
    end
    if (regWr && regAddr == ascr_pkg::ADDR_CTRL2) begin
      n.ctrl2 = regWrData;
      // enable dropped while a frame is on the line
      if (r.ctrl2[ascr_pkg::C2_TXEN] && !regWrData[ascr_pkg::C2_TXEN] &&
          r.txState == ascr_pkg::TX_SHIFT) begin
        n.teDropped = 1'b1;
      end
      if (!r.ctrl2[ascr_pkg::C2_TXEN] && regWrData[ascr_pkg::C2_TXEN]) begin
        n.txDelay = BIT_FULL;
        n.teEver  = 1'b1;
        // low then high during transmission asks for a preamble
        if (r.teDropped || n.teDropped) begin
          n.pendPreamble = 1'b1;
          n.teDropped    = 1'b0;
        end
      end
      // a break request survives being cleared before it is sent
      if (regWrData[ascr_pkg::C2_BRK]) begin
        n.pendBreak = 1'b1;
      end
    end

    // ---- data port and flag clear sequences
    if (regRd && regAddr == ascr_pkg::ADDR_STATUS) begin
      n.statusRead = 1'b1;
    end
    if (dataWr) begin
      n.txHold     = regWrData;
      n.status[7]  = 1'b0;  // hold register now full
      n.statusRead = 1'b0;
      if (r.statusRead) begin
        n.status[6] = 1'b0;
      end
    end
    if (dataRd) begin
      n.statusRead = 1'b0;
      if (r.statusRead) begin
        n.status[5:0] = 6'h00;  // clears come before sets below
      end
    end

    // ---- transmitter
    if (r.txDelay != 16'h0000) begin
      n.txDelay = r.txDelay - 16'h0001;
    end
    // no new frame while stopped for low power or during a data write
    txStartOk = r.ctrl2[ascr_pkg::C2_TXEN] && (r.txDelay == 16'h0000) &&
                !r.ctrl1[ascr_pkg::C1_LPD] && !dataWr;
    case (r.txState)
      ascr_pkg::TX_IDLE: begin
        n.txBitsLeft = r.ctrl1[ascr_pkg::C1_WLEN] ? ascr_pkg::FRAME_BITS_9
                                                  : ascr_pkg::FRAME_BITS_8;
        n.txBaud     = BIT_LAST;
        if (txStartOk && (r.pendBreak || r.ctrl2[ascr_pkg::C2_BRK])) begin
          // break: every bit time of the frame low
          n.txState   = ascr_pkg::TX_SHIFT;
          n.txKind    = ascr_pkg::K_BRK;
          n.txShift   = 11'h000;
          n.pendBreak = 1'b0;
        end else if (txStartOk && r.pendPreamble) begin
          // preamble: one frame of idle line
          n.txState      = ascr_pkg::TX_SHIFT;
          n.txKind       = ascr_pkg::K_PRE;
          n.txShift      = 11'h7FF;
          n.pendPreamble = 1'b0;
        end else if (txStartOk && !r.status[7]) begin
          // parity settings are sampled only here, so they bind per byte
          txByte = r.txHold;
          if (r.ctrl1[ascr_pkg::C1_PAREN] && !r.ctrl1[ascr_pkg::C1_WLEN]) begin
            txByte[7] = (^r.txHold[6:0]) ^ r.ctrl1[ascr_pkg::C1_PARSEL];
          end
          txNinth = r.ctrl1[ascr_pkg::C1_PAREN] ?
                    ((^r.txHold) ^ r.ctrl1[ascr_pkg::C1_PARSEL])
                    : r.ctrl1[ascr_pkg::C1_TX8];
          n.txState   = ascr_pkg::TX_SHIFT;
          n.txKind    = ascr_pkg::K_DATA;
          n.txShift   = r.ctrl1[ascr_pkg::C1_WLEN] ? {1'b1, txNinth, txByte, 1'b0}
                                                   : {2'b11, txByte, 1'b0};
          n.status[7] = 1'b1;  // hold register moved into the shifter
        end
      end
      ascr_pkg::TX_SHIFT: begin
        if (r.txBaud != 16'h0000) begin
          n.txBaud = r.txBaud - 16'h0001;
        end else if (r.txBitsLeft == 4'h1) begin
          // last bit time over; only data frames report completion
          n.txState = ascr_pkg::TX_IDLE;
          if (r.txKind == ascr_pkg::K_DATA) begin
            n.status[6] = 1'b1;
          end
        end else begin
          n.txShift    = {1'b1, r.txShift[10:1]};
          n.txBitsLeft = r.txBitsLeft - 4'h1;
          n.txBaud     = BIT_LAST;
        end
      end
      default: begin
        n.txState = ascr_pkg::TX_IDLE;
      end
    endcase

    // ---- receiver
    case (r.rxState)
      ascr_pkg::RX_HUNT: begin
        if (!r.ctrl2[ascr_pkg::C2_RXEN] || r.ctrl1[ascr_pkg::C1_LPD]) begin
          n.rxIdleCnt = 16'h0000;
        end else if (!rxd) begin
          // falling edge: latch frame settings for this word
          n.rxIdleCnt  = 16'h0000;
          n.rxState    = ascr_pkg::RX_SHIFT;
          n.rxBaud     = BIT_HALF;
          n.rxBitsLeft = r.ctrl1[ascr_pkg::C1_WLEN] ? ascr_pkg::FRAME_BITS_9
                                                    : ascr_pkg::FRAME_BITS_8;
          n.rxNine     = r.ctrl1[ascr_pkg::C1_WLEN];
          n.rxPar      = r.ctrl1[ascr_pkg::C1_PAREN];
          n.rxParOdd   = r.ctrl1[ascr_pkg::C1_PARSEL];
        end else if (r.rxIdleCnt != idleLim) begin
          n.rxIdleCnt = r.rxIdleCnt + 16'h0001;
        end else if (r.rxArmed) begin
          // a whole frame of high line after data counts as idle
          n.rxArmed = 1'b0;
          if (!r.ctrl2[ascr_pkg::C2_MUTE]) begin
            n.status[4] = 1'b1;
          end else if (!r.ctrl1[ascr_pkg::C1_WAKE]) begin
            n.ctrl2[ascr_pkg::C2_MUTE] = 1'b0;
          end
        end
      end
      ascr_pkg::RX_SHIFT: begin
        rxWord = {rxd, r.rxShift[10:1]};
        if (!r.ctrl2[ascr_pkg::C2_RXEN]) begin
          n.rxState = ascr_pkg::RX_HUNT;
        end else if (r.rxBaud != 16'h0000) begin
          n.rxBaud = r.rxBaud - 16'h0001;
        end else begin
          n.rxShift    = rxWord;
          n.rxBitsLeft = r.rxBitsLeft - 4'h1;
          n.rxBaud     = BIT_LAST;
          if (rxd && r.rxBaud == BIT_HALF) begin
            n.rxState = ascr_pkg::RX_HUNT;  // glitch: start bit gone at centre
          end
          if (rxd && ((r.rxNine && r.rxBitsLeft == ascr_pkg::FRAME_BITS_9) ||
                      (!r.rxNine && r.rxBitsLeft == ascr_pkg::FRAME_BITS_8))) begin
            n.rxState = ascr_pkg::RX_HUNT;
          end
          if (r.rxBitsLeft == 4'h1) begin
            n.rxState  = ascr_pkg::RX_HUNT;
            rxData     = r.rxNine ? rxWord[8:1] : rxWord[9:2];
            rxNinthBit = rxWord[9];
            rxMsb      = r.rxNine ? rxNinthBit : rxData[7];
            rxParBad   = r.rxPar && (r.rxNine ? ((^{rxNinthBit, rxData}) ^ r.rxParOdd)
                                              : ((^rxData) ^ r.rxParOdd));
            rxAccept   = !r.ctrl2[ascr_pkg::C2_MUTE];
            if (r.ctrl2[ascr_pkg::C2_MUTE] && r.ctrl1[ascr_pkg::C1_WAKE] && rxMsb) begin
              // address mark wakes the receiver and keeps this word
              n.ctrl2[ascr_pkg::C2_MUTE] = 1'b0;
              rxAccept                   = 1'b1;
            end
          end
        end
      end
      default: begin
        n.rxState = ascr_pkg::RX_HUNT;
      end
    endcase
    if (rxAccept) begin
      n.rxArmed = 1'b1;
      if (r.status[5]) begin
        n.status[3] = 1'b1;  // overrun keeps the held byte
      end else begin
        n.rxHold    = rxData;
        n.status[5] = 1'b1;
        n.status[1] = !rxWord[10];  // stop bit missing
        n.status[0] = rxParBad;
        if (r.rxNine) begin
          n.ctrl1[ascr_pkg::C1_RX8] = rxNinthBit;
        end
      end
    end

    // ---- outputs
    n.txd    = (n.txState == ascr_pkg::TX_SHIFT) ? n.txShift[0] : 1'b1;
    n.txdOeN = !((n.teEver && (n.ctrl2[ascr_pkg::C2_TXEN] || n.ctrl2[ascr_pkg::C2_RXEN])) ||
                 n.txState == ascr_pkg::TX_SHIFT);
    n.irq    = (r.ctrl2[ascr_pkg::C2_TXEIRQ] && r.status[7]) ||
               (r.ctrl2[ascr_pkg::C2_TXDIRQ] && r.status[6]) ||
               (r.ctrl2[ascr_pkg::C2_RXIRQ] && (r.status[5] || r.status[3])) ||
               (r.ctrl2[ascr_pkg::C2_IDLIRQ] && r.status[4]) ||
               (r.ctrl1[ascr_pkg::C1_PARIRQ] && r.status[0]);
    n.rdata  = 8'h00;
    if (regRd) begin
      case (regAddr)
        ascr_pkg::ADDR_STATUS: n.rdata = r.status;
        ascr_pkg::ADDR_DATA:   n.rdata = r.rxHold;
        ascr_pkg::ADDR_CTRL1:  n.rdata = r.ctrl1;
        ascr_pkg::ADDR_CTRL2:  n.rdata = r.ctrl2;
        default:               n.rdata = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r         <= '0;
      r.ctrl1   <= ascr_pkg::CTRL1_RESET;
      r.ctrl2   <= ascr_pkg::CTRL2_RESET;
      r.status  <= ascr_pkg::STATUS_RESET;
      r.txState <= ascr_pkg::TX_IDLE;
      r.txKind  <= ascr_pkg::K_DATA;
      r.rxState <= ascr_pkg::RX_HUNT;
      r.txd     <= 1'b1;
      r.txdOeN  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign regRdData = r.rdata;
  assign txd       = r.txd;
  assign txdOeN    = r.txdOeN;
  assign serialIrq = r.irq;

  // ========================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_data_start;
    $rose(r.txState == ascr_pkg::TX_SHIFT) && r.txKind == ascr_pkg::K_DATA;
  endsequence

  a_irq_parity: assert property ((r.status[0] && r.ctrl1[0]) |=> serialIrq)
    else $error("parity error did not interrupt");
  a_irq_quiet: assert property ((r.ctrl2[7:4] == 4'h0 && !r.ctrl1[0]) |=> !serialIrq)
    else $error("interrupt with all enables clear");
  a_irq_txempty: assert property ((r.status[7] && r.ctrl2[7]) |=> serialIrq)
    else $error("transmit empty did not interrupt");
  a_irq_txdone: assert property ((r.status[6] && r.ctrl2[6]) |=> serialIrq)
    else $error("transmit complete did not interrupt");
  a_irq_rxdata: assert property (((r.status[5] || r.status[3]) && r.ctrl2[5]) |=> serialIrq)
    else $error("receive event did not interrupt");
  a_irq_idle: assert property ((r.status[4] && r.ctrl2[4]) |=> serialIrq)
    else $error("idle line did not interrupt");
  a_line_idle_high: assert property (r.txState == ascr_pkg::TX_IDLE |-> txd)
    else $error("line not high while idle");
  a_frame_start_low: assert property (s_data_start |-> !txd)
    else $error("data frame did not open with a low start bit");
  a_enable_delay: assert property ($rose(r.ctrl2[3]) |-> r.txDelay == BIT_FULL)
    else $error("enable delay not loaded");
  a_delay_holds: assert property ((r.txDelay != 16'h0000 && r.txState == ascr_pkg::TX_IDLE)
                                  |=> r.txState == ascr_pkg::TX_IDLE)
    else $error("frame began inside the enable delay");
  a_no_tc_extra: assert property ((r.txState == ascr_pkg::TX_SHIFT && r.txKind != ascr_pkg::K_DATA)
                                  |=> !$rose(r.status[6]))
    else $error("complete flag after preamble or break");
  a_pin_released: assert property (!r.teEver |-> txdOeN)
    else $error("pin driven before transmitter ever enabled");
  a_lowpower_stop: assert property ((r.ctrl1[5] && r.txState == ascr_pkg::TX_IDLE)
                                    |=> r.txState == ascr_pkg::TX_IDLE)
    else $error("frame began while disabled for low power");
  a_rx_cfg_hold: assert property ((r.rxState == ascr_pkg::RX_SHIFT &&
                                   $past(r.rxState) == ascr_pkg::RX_SHIFT)
                                  |-> $stable(r.rxPar) && $stable(r.rxParOdd))
    else $error("receive parity settings changed mid word");

endmodule
`default_nettype wire

// >>> testbench/ascr_remote.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// remote asynchronous transceiver on the far end of the line
module ascr_remote #(
  parameter int BITC = 8  // clocks per bit time
) (
  // clock and frame length
  input  wire logic clock,
  input  wire logic nine,
  // serial line
  input  wire logic txd,
  input  wire logic txdOeN,
  output logic      rxd
);
  logic [9:0] got[$];  // words seen on txd, stop bit on top

  // the line idles high, as a pulled-up line would
  initial rxd = 1'b1;

  // hunt a low start while the pin is driven, sample mid-bit, lsb first
  always begin : hunt
    logic [9:0] w;
    @(negedge txd iff txdOeN === 1'b0);
    repeat (BITC / 2) @(posedge clock);
    w = '0;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BITC) @(posedge clock);
      w[i] = txd;
    end
    repeat (BITC) @(posedge clock);
    w[9] = txd;
    got.push_back(w);
  end

  // one frame towards the block: low start, lsb first, high stop
  task automatic sendFrame(input logic [8:0] w);
    logic [10:0] f;
    f = nine ? {1'h1, w, 1'h0} : {2'h3, w[7:0], 1'h0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (BITC - 1) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// self-checking bench for the serial control block
module tb_top;
  localparam int BITC = 8;  // short bit time keeps the run brief
  // design connections and bench state
  logic       clock, rst, regWr, regRd, rxd, txd, txdOeN, serialIrq, nine;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, rv;
  logic [7:0] cfgs[6] = '{8'h00, 8'h04, 8'h06, 8'h10, 8'h50, 8'h16};
  int         failures = 0, n_tests = 0, seed = 32'h3865, d;

  ascr_top #(.BIT_CYCLES(BITC)) dut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .rxd(rxd), .txd(txd), .txdOeN(txdOeN),
    .serialIrq(serialIrq));
  ascr_remote #(.BITC(BITC)) rem (
    .clock(clock), .nine(nine), .txd(txd), .txdOeN(txdOeN), .rxd(rxd));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // helpers
  task automatic finish_test();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] ex, input logic [9:0] gt);
    n_tests++;
    if (gt !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  // let n edges pass, then step off the edge so updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    rv = regRdData;
  endtask
  // model of the frame for byte v under control-one value c
  function automatic logic [9:0] frameOf(input int v, input int c);
    int p;
    p = c[4] ? $countones(v & 32'hFF) : $countones(v & 32'h7F);
    p = (p + c[1]) % 2;
    if (c[4])
      return {1'h1, c[2] ? p[0] : c[6], 8'(v)};
    return {2'h2, c[2] ? p[0] : v[7], 7'(v)};
  endfunction
  // wait for the remote to see a word; leave the stop bit time to finish
  task automatic expectFrame(input logic [9:0] ex);
    for (int i = 0; i < 40 * BITC && rem.got.size() == 0; i++)
      @(posedge clock);
    if (rem.got.size() == 0)
      rem.got.push_back(10'h000);
    chk("frame", ex, rem.got.pop_front());
    settle(BITC);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {regWr, regRd, nine, regAddr, regWrData} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(ascr_pkg::ADDR_CTRL2);
    chk("ctrl2 reset", 8'h00, rv);
    rd(ascr_pkg::ADDR_STATUS);
    chk("status reset", ascr_pkg::STATUS_RESET, rv);
    chk("pin released", 1'h1, txdOeN);
    d = $random(seed) & 32'hF0;
    wr(ascr_pkg::ADDR_CTRL2, 8'(d));
    rd(ascr_pkg::ADDR_CTRL2);
    chk("ctrl2 rw", 8'(d), rv);
    // empty flag is set after reset, so the enable alone decides
    wr(ascr_pkg::ADDR_CTRL2, 8'h80);
    settle(2);
    chk("empty irq", 1'h1, serialIrq);
    wr(ascr_pkg::ADDR_CTRL2, 8'h00);
    settle(2);
    chk("irq masked", 1'h0, serialIrq);
    wr(ascr_pkg::ADDR_CTRL1, 8'h80);
    rd(ascr_pkg::ADDR_CTRL1);
    chk("ninth rx ro", 8'h00, rv);
    // data written at once after enabling must still wait a bit time
    wr(ascr_pkg::ADDR_CTRL2, 8'h08);
    wr(ascr_pkg::ADDR_DATA, 8'h5A);
    for (int i = 0; i < BITC - 3; i++) begin
      settle(1);
      chk("enable delay", 1'h1, txd);
    end
    chk("pin driven", 1'h0, txdOeN);
    expectFrame(frameOf(32'h5A, 0));
    foreach (cfgs[k]) begin
      nine = cfgs[k][4];
      wr(ascr_pkg::ADDR_CTRL1, cfgs[k]);
      d = $random(seed);
      wr(ascr_pkg::ADDR_DATA, 8'(d));
      expectFrame(frameOf(d, cfgs[k]));
    end
    // low-power bit holds a waiting byte back until it is cleared
    nine = 1'h0;
    wr(ascr_pkg::ADDR_CTRL1, 8'h20);
    wr(ascr_pkg::ADDR_DATA, 8'h3C);
    settle(30 * BITC);
    chk("low power hold", 10'h000, 10'(rem.got.size()));
    wr(ascr_pkg::ADDR_CTRL1, 8'h00);
    expectFrame(frameOf(32'h3C, 0));
    wr(ascr_pkg::ADDR_CTRL2, 8'h48);
    settle(2);
    chk("done irq", 1'h1, serialIrq);
    // nine-bit reception with both values of the ninth bit
    for (int k = 0; k < 2; k++) begin
      nine = 1'h1;
      wr(ascr_pkg::ADDR_CTRL1, 8'h10);
      wr(ascr_pkg::ADDR_CTRL2, 8'h2C);
      d = $random(seed);
      rem.sendFrame({k[0], 8'(d)});
      settle(2);
      chk("rx irq", 1'h1, serialIrq);
      rd(ascr_pkg::ADDR_CTRL1);
      chk("ninth rx", {k[0], 7'h10}, rv);
      rd(ascr_pkg::ADDR_STATUS);
      rd(ascr_pkg::ADDR_DATA);
      chk("rx data", 8'(d), rv);
      settle(2);
      chk("rx irq clear", 1'h0, serialIrq);
    end
    // wrong even parity on a nine-bit word, parity enable and parity irq enable set
    wr(ascr_pkg::ADDR_CTRL1, 8'h15);
    wr(ascr_pkg::ADDR_CTRL2, 8'h0C);
    d = $random(seed);
    rem.sendFrame({~^d[7:0], 8'(d)});
    settle(2);
    chk("parity irq", 1'h1, serialIrq);
    rd(ascr_pkg::ADDR_STATUS);
    chk("parity flag", 1'h1, rv[0]);
    rd(ascr_pkg::ADDR_DATA);
    // mute with address-mark wake, entered after data has been received
    wr(ascr_pkg::ADDR_CTRL1, 8'h18);
    wr(ascr_pkg::ADDR_CTRL2, 8'h2E);
    rem.sendFrame({1'b0, 8'h11});
    settle(2);
    chk("muted rx", 1'h0, serialIrq);
    rem.sendFrame({1'b1, 8'h22});
    settle(2);
    chk("wake irq", 1'h1, serialIrq);
    rd(ascr_pkg::ADDR_CTRL2);
    chk("mute cleared", 8'h2C, rv);
    rd(ascr_pkg::ADDR_STATUS);
    rd(ascr_pkg::ADDR_DATA);
    chk("wake data", 8'h22, rv);
    // a whole frame of high line after the word raises the idle flag
    wr(ascr_pkg::ADDR_CTRL2, 8'h1C);
    settle(14 * BITC);
    chk("idle irq", 1'h1, serialIrq);
    // break set then cleared sends exactly one all-low word
    nine = 1'h0;
    wr(ascr_pkg::ADDR_CTRL1, 8'h00);
    wr(ascr_pkg::ADDR_CTRL2, 8'h09);
    wr(ascr_pkg::ADDR_CTRL2, 8'h08);
    expectFrame(10'h000);
    settle(15 * BITC);
    chk("one break", 10'h000, 10'(rem.got.size()));
    finish_test();
  end

  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
